// ==== bus_master_pkg.sv ====
/*
  Constants, commands and states of the backplane bus master controller.
  Assumes a 10 MHz core clock and a bus whose strobes are seen as active-high
  logical levels after the bus transceivers.

*/
package bus_master_pkg;

  localparam int CLK_PERIOD_NS = 100;

  localparam int ADDR_SETUP_NS   = 150;
  localparam int ADDR_HOLD_NS    = 100;
  localparam int DATA_TAKE_NS    = 200;
  localparam int NEXT_READ_NS    = 150;
  localparam int RMW_GAP_NS      = 200;
  localparam int DATA_SETUP_NS   = 100;
  localparam int WRITE_HOLD_NS   = 150;
  localparam int DATA_KEEP_NS    = 100;
  localparam int SYNC_AFTER_WR_NS = 175;
  localparam int SYNC_AFTER_RPLY_NS = 250;
  localparam int SYNC_IDLE_NS    = 300;
  localparam int GRANT_SETTLE_NS = 250;
  localparam int REPLY_TIMEOUT_US = 8000;

  localparam int TW = 17;

  function automatic logic [TW-1:0] ns_to_cycles(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    if (c < 1) c = 1;
    return TW'(c);
  endfunction

  localparam logic [TW-1:0] ADDR_SETUP_CYC   = ns_to_cycles(ADDR_SETUP_NS);
  localparam logic [TW-1:0] ADDR_HOLD_CYC    = ns_to_cycles(ADDR_HOLD_NS);
  localparam logic [TW-1:0] DATA_TAKE_CYC    = ns_to_cycles(DATA_TAKE_NS);
  localparam logic [TW-1:0] NEXT_READ_CYC    = ns_to_cycles(NEXT_READ_NS);
  localparam logic [TW-1:0] RMW_GAP_CYC      = ns_to_cycles(RMW_GAP_NS);
  localparam logic [TW-1:0] DATA_SETUP_CYC   = ns_to_cycles(DATA_SETUP_NS);
  localparam logic [TW-1:0] WRITE_HOLD_CYC   = ns_to_cycles(WRITE_HOLD_NS);
  localparam logic [TW-1:0] DATA_KEEP_CYC    = ns_to_cycles(DATA_KEEP_NS);
  localparam logic [TW-1:0] SYNC_AFTER_WR_CYC = ns_to_cycles(SYNC_AFTER_WR_NS - DATA_KEEP_NS);
  localparam logic [TW-1:0] SYNC_AFTER_RPLY_CYC =
    ns_to_cycles(SYNC_AFTER_RPLY_NS - DATA_TAKE_NS);
  localparam logic [TW-1:0] SYNC_IDLE_CYC    = ns_to_cycles(SYNC_IDLE_NS);
  localparam logic [TW-1:0] GRANT_SETTLE_CYC = ns_to_cycles(GRANT_SETTLE_NS);
  localparam int REPLY_TIMEOUT_CYC = REPLY_TIMEOUT_US * 1000 / CLK_PERIOD_NS;

  localparam int AW = 22;
  localparam int DW = 16;
  localparam logic [3:0] BLOCK_MAX = 4'h8;

  typedef enum logic [1:0] {
    OP_READ  = 2'h0,
    OP_RMW   = 2'h1,
    OP_BLOCK = 2'h2
  } op_t;

  typedef enum logic [15:0] {
    S_IDLE  = 16'h0001,
    S_ADDR  = 16'h0002,
    S_AHOLD = 16'h0004,
    S_RPLY  = 16'h0008,
    S_TAKE  = 16'h0010,
    S_ROFF  = 16'h0020,
    S_NEXT  = 16'h0040,
    S_WSET  = 16'h0080,
    S_WSTR  = 16'h0100,
    S_WRPLY = 16'h0200,
    S_WHOLD = 16'h0400,
    S_WOFF  = 16'h0800,
    S_END   = 16'h1000,
    S_RECOV = 16'h2000,
    S_GRANT = 16'h4000,
    S_DMA   = 16'h8000
  } state_t;

endpackage

// ==== word_stream_if.sv ====
/*
  Valid/ready word stream between the bus master engine and its read FIFO.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
interface word_stream_if #(parameter int WIDTH = 16);
  logic             valid;
  logic             ready;
  logic [WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ==== interval_timer.sv ====
/*
  Down counter for bus timing intervals: load a count, expired after that many
  clocks. Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module interval_timer #(
  parameter int WIDTH = 17
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_val,
  output      logic             expired
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;

  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = load_val;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - WIDTH'(1);
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end

  assign expired = (cnt_reg == '0);
endmodule

// ==== word_fifo.sv ====
/*
  Synchronous FIFO with registered show-ahead output. Push side is a word
  stream interface, pop side plain valid/ready ports driven from flops.
  Assumes one clock and an active-low asynchronous reset.
*/
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  word_stream_if.snk            wr,
  output      logic             rd_valid,
  input  wire logic             rd_ready,
  output      logic [WIDTH-1:0] rd_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wptr_reg;
  logic [PW-1:0]    wptr_next;
  logic [PW-1:0]    rptr_reg;
  logic [PW-1:0]    rptr_next;
  logic [PW:0]      cnt_reg;
  logic [PW:0]      cnt_next;
  logic             valid_reg;
  logic             valid_next;
  logic [WIDTH-1:0] data_reg;
  logic [WIDTH-1:0] data_next;
  logic             push;
  logic             pop;

  assign wr.ready = (cnt_reg != (PW+1)'(DEPTH));
  assign push     = wr.valid && wr.ready;
  assign pop      = valid_reg && rd_ready;

  always_comb begin
    wptr_next  = push ? wptr_reg + PW'(1) : wptr_reg;
    rptr_next  = pop ? rptr_reg + PW'(1) : rptr_reg;
    cnt_next   = cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
    valid_next = (cnt_next != '0);
    data_next  = (push && (wptr_reg == rptr_next)) ? wr.data : mem[rptr_next];
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wptr_reg] <= wr.data;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr_reg  <= '0;
      rptr_reg  <= '0;
      cnt_reg   <= '0;
      valid_reg <= 1'b0;
      data_reg  <= '0;
    end else begin
      wptr_reg  <= wptr_next;
      rptr_reg  <= rptr_next;
      cnt_reg   <= cnt_next;
      valid_reg <= valid_next;
      data_reg  <= data_next;
    end
  end

  assign rd_valid = valid_reg;
  assign rd_data  = data_reg;
endmodule

// ==== backplane_bus_master.sv ====
/*
  Backplane bus master and DMA arbiter: runs word read, read-modify-write and
  block read cycles, hands the bus to a requesting DMA module, and queues read
  words in a FIFO. Assumes pins are synchronous to core_clk and seen as
  active-high asserted levels after the bus transceivers.
*/
`timescale 1ns/1ps
module backplane_bus_master #(
  parameter int REPLY_TIMEOUT_CYC = bus_master_pkg::REPLY_TIMEOUT_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        cmd_valid,
  output      logic        cmd_ready,
  input  wire logic [1:0]  cmd_op,
  input  wire logic [21:0] cmd_addr,
  input  wire logic        cmd_io_page,
  input  wire logic [3:0]  cmd_count,
  input  wire logic [15:0] cmd_wdata,
  input  wire logic        cmd_byte,
  output      logic        rd_valid,
  input  wire logic        rd_ready,
  output      logic [15:0] rd_data,
  output      logic        done,
  output      logic        timeout,
  output      logic        cycle_sync_strobe_out,
  input  wire logic        cycle_sync_strobe_in,
  output      logic        read_strobe,
  output      logic        write_data_strobe,
  input  wire logic        slave_reply,
  input  wire logic        block_continue,
  output      logic        io_page_select_block_request,
  output      logic        write_byte_line,
  input  wire logic [21:0] data_address_lines_in,
  output      logic [21:0] data_address_lines_out,
  output      logic [21:0] data_address_lines_oe,
  input  wire logic        dma_request_line,
  output      logic        dma_grant_output,
  input  wire logic        grant_acknowledge
);
  localparam int TW = bus_master_pkg::TW;
  localparam logic [TW-1:0] TIMEOUT_LOAD = TW'(REPLY_TIMEOUT_CYC);

  word_stream_if #(.WIDTH(bus_master_pkg::DW)) push_if ();

  bus_master_pkg::state_t state_reg;
  bus_master_pkg::state_t state_next;
  bus_master_pkg::op_t    op_reg;
  bus_master_pkg::op_t    op_next;
  logic [21:0] addr_reg;
  logic [21:0] addr_next;
  logic [15:0] wdata_reg;
  logic [15:0] wdata_next;
  logic        byte_reg;
  logic        byte_next;
  logic [3:0]  left_reg;
  logic [3:0]  left_next;
  logic        cont_reg;
  logic        cont_next;
  logic        sync_reg;
  logic        sync_next;
  logic        din_reg;
  logic        din_next;
  logic        dout_reg;
  logic        dout_next;
  logic        bs7_reg;
  logic        bs7_next;
  logic        wtbt_reg;
  logic        wtbt_next;
  logic [21:0] dal_reg;
  logic [21:0] dal_next;
  logic        oe_reg;
  logic        oe_next;
  logic        ready_reg;
  logic        ready_next;
  logic        done_reg;
  logic        done_next;
  logic        tmo_reg;
  logic        tmo_next;
  logic        grant_reg;
  logic        grant_next;
  logic        tload;
  logic [TW-1:0] tval;
  logic        texp;

  function automatic logic more_words(input logic [3:0] left);
    return left > 4'h1;
  endfunction

  interval_timer #(.WIDTH(TW)) u_timer (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .load     (tload),
    .load_val (tval),
    .expired  (texp)
  );

  word_fifo #(.WIDTH(bus_master_pkg::DW), .DEPTH(8)) u_fifo (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .wr       (push_if.snk),
    .rd_valid (rd_valid),
    .rd_ready (rd_ready),
    .rd_data  (rd_data)
  );

  assign push_if.data  = data_address_lines_in[bus_master_pkg::DW-1:0];
  assign push_if.valid = (state_reg == bus_master_pkg::S_TAKE) && texp;

  always_comb begin
    state_next = state_reg;
    op_next    = op_reg;
    addr_next  = addr_reg;
    wdata_next = wdata_reg;
    byte_next  = byte_reg;
    left_next  = left_reg;
    cont_next  = cont_reg;
    sync_next  = sync_reg;
    din_next   = din_reg;
    dout_next  = dout_reg;
    bs7_next   = bs7_reg;
    wtbt_next  = wtbt_reg;
    dal_next   = dal_reg;
    oe_next    = oe_reg;
    done_next  = 1'b0;
    tmo_next   = tmo_reg;
    grant_next = grant_reg;
    tload      = 1'b0;
    tval       = '0;
    case (state_reg)
      bus_master_pkg::S_IDLE: begin
        if (dma_request_line && !cycle_sync_strobe_in) begin
          grant_next = 1'b1;
          state_next = bus_master_pkg::S_GRANT;
        end else if (cmd_valid && ready_reg && !cycle_sync_strobe_in) begin
          op_next    = bus_master_pkg::op_t'(cmd_op);
          addr_next  = cmd_addr;
          wdata_next = cmd_wdata;
          byte_next  = cmd_byte;
          left_next  = (cmd_op != bus_master_pkg::OP_BLOCK || cmd_count == 4'h0) ? 4'h1 :
                       (cmd_count > bus_master_pkg::BLOCK_MAX) ? bus_master_pkg::BLOCK_MAX :
                       cmd_count;
          dal_next   = cmd_addr;
          oe_next    = 1'b1;
          bs7_next   = cmd_io_page;
          wtbt_next  = 1'b0;
          tmo_next   = 1'b0;
          tload      = 1'b1;
          tval       = bus_master_pkg::ADDR_SETUP_CYC;
          state_next = bus_master_pkg::S_ADDR;
        end
      end
      bus_master_pkg::S_ADDR: begin
        if (texp) begin
          sync_next  = 1'b1;
          tload      = 1'b1;
          tval       = bus_master_pkg::ADDR_HOLD_CYC;
          state_next = bus_master_pkg::S_AHOLD;
        end
      end
      bus_master_pkg::S_AHOLD: begin
        if (texp) begin
          oe_next    = 1'b0;
          din_next   = 1'b1;
          bs7_next   = more_words(left_reg);
          tload      = 1'b1;
          tval       = TIMEOUT_LOAD;
          state_next = bus_master_pkg::S_RPLY;
        end
      end
      bus_master_pkg::S_RPLY, bus_master_pkg::S_WRPLY: begin
        if (slave_reply) begin
          cont_next  = block_continue;
          tload      = 1'b1;
          tval       = (state_reg == bus_master_pkg::S_RPLY) ?
                       bus_master_pkg::DATA_TAKE_CYC : bus_master_pkg::WRITE_HOLD_CYC;
          state_next = (state_reg == bus_master_pkg::S_RPLY) ?
                       bus_master_pkg::S_TAKE : bus_master_pkg::S_WHOLD;
        end else if (texp) begin
          din_next   = 1'b0;
          dout_next  = 1'b0;
          oe_next    = 1'b0;
          bs7_next   = 1'b0;
          tmo_next   = 1'b1;
          tload      = 1'b1;
          tval       = bus_master_pkg::SYNC_AFTER_WR_CYC;
          state_next = bus_master_pkg::S_END;
        end
      end
      bus_master_pkg::S_TAKE: begin
        if (texp && push_if.ready) begin
          din_next   = 1'b0;
          left_next  = left_reg - 4'h1;
          state_next = bus_master_pkg::S_ROFF;
        end
      end
      bus_master_pkg::S_ROFF: begin
        if (!slave_reply) begin
          tload = 1'b1;
          if (op_reg == bus_master_pkg::OP_RMW) begin
            tval       = bus_master_pkg::RMW_GAP_CYC;
            state_next = bus_master_pkg::S_WSET;
          end else if (op_reg == bus_master_pkg::OP_BLOCK && left_reg != 4'h0 &&
                       cont_reg) begin
            tval       = bus_master_pkg::NEXT_READ_CYC;
            state_next = bus_master_pkg::S_NEXT;
          end else begin
            bs7_next   = 1'b0;
            tval       = bus_master_pkg::SYNC_AFTER_RPLY_CYC;
            state_next = bus_master_pkg::S_END;
          end
        end
      end
      bus_master_pkg::S_NEXT: begin
        if (texp) begin
          din_next   = 1'b1;
          bs7_next   = more_words(left_reg);
          tload      = 1'b1;
          tval       = TIMEOUT_LOAD;
          state_next = bus_master_pkg::S_RPLY;
        end
      end
      bus_master_pkg::S_WSET: begin
        if (texp) begin
          dal_next   = {6'h00, wdata_reg};
          oe_next    = 1'b1;
          wtbt_next  = byte_reg;
          tload      = 1'b1;
          tval       = bus_master_pkg::DATA_SETUP_CYC;
          state_next = bus_master_pkg::S_WSTR;
        end
      end
      bus_master_pkg::S_WSTR: begin
        if (texp) begin
          dout_next  = 1'b1;
          tload      = 1'b1;
          tval       = TIMEOUT_LOAD;
          state_next = bus_master_pkg::S_WRPLY;
        end
      end
      bus_master_pkg::S_WHOLD: begin
        if (texp) begin
          dout_next  = 1'b0;
          tload      = 1'b1;
          tval       = bus_master_pkg::DATA_KEEP_CYC;
          state_next = bus_master_pkg::S_WOFF;
        end
      end
      bus_master_pkg::S_WOFF: begin
        if (texp && !slave_reply) begin
          oe_next    = 1'b0;
          tload      = 1'b1;
          tval       = bus_master_pkg::SYNC_AFTER_WR_CYC;
          state_next = bus_master_pkg::S_END;
        end
      end
      bus_master_pkg::S_END: begin
        if (texp && !slave_reply) begin
          sync_next  = 1'b0;
          wtbt_next  = 1'b0;
          bs7_next   = 1'b0;
          done_next  = 1'b1;
          tload      = 1'b1;
          tval       = bus_master_pkg::SYNC_IDLE_CYC;
          state_next = bus_master_pkg::S_RECOV;
        end
      end
      bus_master_pkg::S_RECOV: begin
        if (texp) begin
          state_next = bus_master_pkg::S_IDLE;
        end
      end
      bus_master_pkg::S_GRANT: begin
        if (grant_acknowledge) begin
          grant_next = 1'b0;
          state_next = bus_master_pkg::S_DMA;
        end else if (!dma_request_line) begin
          grant_next = 1'b0;
          state_next = bus_master_pkg::S_IDLE;
        end
      end
      bus_master_pkg::S_DMA: begin
        if (!grant_acknowledge && !cycle_sync_strobe_in) begin
          tload      = 1'b1;
          tval       = bus_master_pkg::SYNC_IDLE_CYC;
          state_next = bus_master_pkg::S_RECOV;
        end
      end
      default: begin
        state_next = bus_master_pkg::S_IDLE;
        sync_next  = 1'b0;
        din_next   = 1'b0;
        dout_next  = 1'b0;
        oe_next    = 1'b0;
        grant_next = 1'b0;
      end
    endcase
    ready_next = (state_next == bus_master_pkg::S_IDLE) && !(cmd_valid && ready_reg &&
                 state_reg == bus_master_pkg::S_IDLE);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= bus_master_pkg::S_IDLE;
      op_reg    <= bus_master_pkg::OP_READ;
      addr_reg  <= '0;
      wdata_reg <= '0;
      byte_reg  <= 1'b0;
      left_reg  <= '0;
      cont_reg  <= 1'b0;
      sync_reg  <= 1'b0;
      din_reg   <= 1'b0;
      dout_reg  <= 1'b0;
      bs7_reg   <= 1'b0;
      wtbt_reg  <= 1'b0;
      dal_reg   <= '0;
      oe_reg    <= 1'b0;
      ready_reg <= 1'b0;
      done_reg  <= 1'b0;
      tmo_reg   <= 1'b0;
      grant_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      op_reg    <= op_next;
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      byte_reg  <= byte_next;
      left_reg  <= left_next;
      cont_reg  <= cont_next;
      sync_reg  <= sync_next;
      din_reg   <= din_next;
      dout_reg  <= dout_next;
      bs7_reg   <= bs7_next;
      wtbt_reg  <= wtbt_next;
      dal_reg   <= dal_next;
      oe_reg    <= oe_next;
      ready_reg <= ready_next;
      done_reg  <= done_next;
      tmo_reg   <= tmo_next;
      grant_reg <= grant_next;
    end
  end

  assign cmd_ready                    = ready_reg;
  assign done                         = done_reg;
  assign timeout                      = tmo_reg;
  assign cycle_sync_strobe_out        = sync_reg;
  assign read_strobe                  = din_reg;
  assign write_data_strobe            = dout_reg;
  assign io_page_select_block_request = bs7_reg;
  assign write_byte_line              = wtbt_reg;
  assign data_address_lines_out       = dal_reg;
  assign data_address_lines_oe        = {22{oe_reg}};
  assign dma_grant_output             = grant_reg;
endmodule

// ==== backplane_bus_master_assertions.sv ====
/*
  Checker of the bus master pin protocol.
  Assumes it is bound to backplane_bus_master and sees only its ports.
*/
`timescale 1ns/1ps
module bus_master_checker (
  input wire logic        core_clk,
  input wire logic        arst_n,
  input wire logic        done,
  input wire logic        cycle_sync_strobe_out,
  input wire logic        read_strobe,
  input wire logic        write_data_strobe,
  input wire logic        slave_reply,
  input wire logic        write_byte_line,
  input wire logic [21:0] data_address_lines_out,
  input wire logic [21:0] data_address_lines_oe,
  input wire logic        dma_request_line,
  input wire logic        dma_grant_output,
  input wire logic        grant_acknowledge
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  a_rmw_gap: assert property (
    $rose(write_data_strobe) |-> !$past(slave_reply) && !$past(slave_reply, 2))
    else $error("write strobe early");
  a_grant_cause: assert property (
    $rose(dma_grant_output) |-> $past(dma_request_line) && !$past(cycle_sync_strobe_out))
    else $error("grant without request");
  a_grant_stop: assert property (
    grant_acknowledge && dma_grant_output |-> ##[1:2] !dma_grant_output)
    else $error("grant held");
  a_dma_owns_bus: assert property (
    grant_acknowledge |-> !cycle_sync_strobe_out && !read_strobe && !write_data_strobe)
    else $error("master active in dma");
  a_read_addr: assert property (
    $rose(cycle_sync_strobe_out) |-> &data_address_lines_oe && !write_byte_line
      && $stable(data_address_lines_out))
    else $error("bad address phase");
  a_first_strobe: assert property (
    $rose(read_strobe) |-> $past(cycle_sync_strobe_out) && data_address_lines_oe == 22'h0)
    else $error("read strobe early");
  a_strobe_gap: assert property (
    $rose(read_strobe) |-> !$past(slave_reply) && !$past(slave_reply, 2))
    else $error("read strobe after reply early");
  a_take_time: assert property (
    $fell(read_strobe) && $past(slave_reply) |-> $past(slave_reply, 3))
    else $error("read strobe dropped early");
  a_sync_end: assert property (
    $fell(cycle_sync_strobe_out) |-> done && !slave_reply && !$past(slave_reply))
    else $error("sync dropped early");
endmodule

bind backplane_bus_master bus_master_checker chk_u (.core_clk, .arst_n, .done,
  .cycle_sync_strobe_out, .read_strobe, .write_data_strobe, .slave_reply, .write_byte_line,
  .data_address_lines_out, .data_address_lines_oe, .dma_request_line, .dma_grant_output,
  .grant_acknowledge);

// ==== slave_dma_model.sv ====
/*
  Behavioural slave and DMA requester facing the bus master.
  Assumes active-high asserted pin levels on one clock.
*/
`timescale 1ns/1ps
module slave_dma_model (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  dly,
  input  wire logic        mute,
  input  wire logic        want_dma,
  input  wire logic        sync,
  input  wire logic        rd,
  input  wire logic        wr,
  input  wire logic        bs7,
  input  wire logic        wtbt,
  input  wire logic [21:0] dal_out,
  input  wire logic [21:0] dal_oe,
  input  wire logic        grant,
  output      logic        reply,
  output      logic        cont,
  output      logic [21:0] dal_in,
  output      logic [16:0] wdat,
  output      logic        req,
  output      logic        ack,
  output      logic        dsync
);
  logic [21:0] adr, last;
  logic        sync_d;
  logic [3:0]  cnt, dcnt;
  assign dal_in = |dal_oe ? dal_out :
                  (reply & !wr) ? {6'h00, adr[15:0] ^ 16'h5A5A} : ~last;
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      {reply, cont, req, ack, dsync, sync_d, adr, last, wdat, cnt, dcnt} <= '0;
    end else begin
      sync_d <= sync;
      last <= dal_in;
      if (sync & !sync_d) adr <= dal_out;
      if ((rd | wr) & !mute & !reply) begin
        cnt <= cnt + 4'h1;
        if (cnt == dly) begin
          {reply, cont, cnt} <= {2'h3, 4'h0};
        end
      end
      if (reply & !rd & !wr) begin
        {reply, cont} <= 2'h0;
        if (bs7 & cont) adr <= adr + 22'h2;
      end
      if (reply & wr) wdat <= {wtbt, dal_out[15:0]};
      if (want_dma & !req & !ack) req <= 1'b1;
      if (req & grant) begin
        {req, ack, dcnt} <= {2'h1, 4'h0};
      end
      if (ack) dcnt <= dcnt + 4'h1;
      dsync <= ack & dcnt >= 4'h3 & dcnt < 4'h6;
      if (ack & dcnt == 4'h7) ack <= 1'b0;
    end
  end
endmodule

// ==== backplane_bus_master_tb.sv ====
/*
  Self-checking bench of the backplane bus master.
  Assumes slave_dma_model on the bus side and the bound checker.
*/
`timescale 1ns/1ps
module backplane_bus_master_tb;
  logic        core_clk = 1'b0, arst_n = 1'b0, cmd_valid = 1'b0, cmd_io_page = 1'b0;
  logic        rd_ready = 1'b0, mute = 1'b0, want_dma = 1'b0, cmd_byte = 1'b1;
  logic [1:0]  cmd_op = 2'h0;
  logic [3:0]  cmd_count = 4'h0, dly = 4'h0;
  logic [21:0] cmd_addr = 22'h0, data_address_lines_in, data_address_lines_out;
  logic [21:0] data_address_lines_oe;
  logic [15:0] cmd_wdata = 16'hC3A5, rd_data;
  logic [16:0] wdat;
  logic        cmd_ready, rd_valid, done, timeout, cycle_sync_strobe_out, read_strobe;
  logic        write_data_strobe, slave_reply, block_continue, write_byte_line;
  logic        cycle_sync_strobe_in, io_page_select_block_request;
  logic        dma_request_line, dma_grant_output, grant_acknowledge;
  int          n_errors = 0, n_checks = 0;

  backplane_bus_master #(.REPLY_TIMEOUT_CYC(20)) dut_u (.*);
  slave_dma_model model_u (.core_clk, .arst_n, .dly, .mute, .want_dma, .wdat,
    .sync(cycle_sync_strobe_out), .rd(read_strobe), .wr(write_data_strobe),
    .bs7(io_page_select_block_request), .wtbt(write_byte_line),
    .dal_out(data_address_lines_out), .dal_oe(data_address_lines_oe),
    .grant(dma_grant_output), .reply(slave_reply), .cont(block_continue),
    .dal_in(data_address_lines_in), .req(dma_request_line), .ack(grant_acknowledge),
    .dsync(cycle_sync_strobe_in));

  always #50 core_clk = ~core_clk;

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [21:0] seen, input logic [21:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic hang(input string what);
    chk(what, 22'h0, 22'h1);
    test_done();
  endtask
  task automatic issue(input logic [1:0] op, input logic [21:0] a, input logic [3:0] n);
    for (int k = 0; cmd_ready !== 1'b1 || grant_acknowledge !== 1'b0; k++) begin
      @(negedge core_clk);
      if (k > 300) hang("cmd_ready");
    end
    {cmd_op, cmd_addr, cmd_count, cmd_valid} = {op, a, n, 1'b1};
    @(negedge core_clk);
    cmd_valid = 1'b0;
  endtask
  task automatic wait_done();
    for (int k = 0; done !== 1'b1; k++) begin
      @(negedge core_clk);
      if (k > 400) hang("done");
    end
  endtask
  task automatic pop(input logic [21:0] a);
    for (int k = 0; rd_valid !== 1'b1; k++) begin
      @(negedge core_clk);
      if (k > 400) hang("rd_valid");
    end
    chk("rd_data", 22'(rd_data), 22'(a[15:0] ^ 16'h5A5A));
    rd_ready = 1'b1;
    @(negedge core_clk);
    rd_ready = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic t_timeout();
    mute = 1'b1;
    issue(2'h0, 22'h000600, 4'h0);
    wait_done();
    chk("timeout", 22'(timeout), 22'h1);
    chk("rd_valid", 22'(rd_valid), 22'h0);
    mute = 1'b0;
    $display("t_timeout end");
  endtask
  task automatic t_word();
    cmd_io_page = 1'b1;
    issue(2'h0, 22'h3FFFFE, 4'h0);
    chk("data_address_lines_out", data_address_lines_out, 22'h3FFFFE);
    chk("io_page_select_block_request", 22'(io_page_select_block_request), 22'h1);
    chk("write_byte_line", 22'(write_byte_line), 22'h0);
    wait_done();
    pop(22'h3FFFFE);
    chk("timeout", 22'(timeout), 22'h0);
    cmd_io_page = 1'b0;
    $display("t_word end");
  endtask
  task automatic t_rmw();
    for (int b = 1; b >= 0; b--) begin
      cmd_byte = 1'(b);
      issue(2'h1, 22'h000400, 4'h0);
      wait_done();
      chk("wdat", 22'(wdat), {5'h00, cmd_byte, cmd_wdata});
      pop(22'h000400);
    end
    $display("t_rmw end");
  endtask
  task automatic t_block_full();
    dly = 4'h2;
    issue(2'h2, 22'h001000, 4'h9);
    wait_done();
    issue(2'h0, 22'h000200, 4'h1);
    repeat (6) @(negedge core_clk);
    chk("read_strobe", 22'(read_strobe), 22'h1);
    for (int i = 0; i < 8; i++) pop(22'h001000 + 22'(2 * i));
    pop(22'h000200);
    dly = 4'h0;
    $display("t_block_full end");
  endtask
  task automatic t_dma();
    want_dma = 1'b1;
    @(negedge core_clk);
    want_dma = 1'b0;
    for (int k = 0; grant_acknowledge !== 1'b1; k++) begin
      @(negedge core_clk);
      if (k > 50) hang("grant");
    end
    chk("cmd_ready", 22'(cmd_ready), 22'h0);
    issue(2'h0, 22'h000800, 4'h0);
    wait_done();
    pop(22'h000800);
    $display("t_dma end");
  endtask

  initial begin
    repeat (8) @(negedge core_clk);
    arst_n = 1'b1;
    @(negedge core_clk);
    t_timeout();
    t_word();
    t_rmw();
    t_block_full();
    t_dma();
    test_done();
  end
endmodule
